// ===== verilog/batie_defs.svh
// constants for the bit and transfer instruction executor
// assumes inclusion by the executor only
`ifndef BATIE_DEFS_SVH
`define BATIE_DEFS_SVH

// status register bit positions
`define BATIE_FLAG_CARRY     3'd0
`define BATIE_FLAG_ZERO      3'd1
`define BATIE_FLAG_NEG       3'd2
`define BATIE_FLAG_OVF       3'd3
`define BATIE_FLAG_SIGN      3'd4
`define BATIE_FLAG_HALF      3'd5
`define BATIE_FLAG_XFER      3'd6
`define BATIE_FLAG_INT       3'd7

// low register index of each pointer pair
`define BATIE_FIRST_PTR_LO   5'h1a
`define BATIE_SECOND_PTR_LO  5'h1c
`define BATIE_THIRD_PTR_LO   5'h1e

// reset values
`define BATIE_STATUS_RESET   8'h00
`define BATIE_SP_RESET       16'h00ff
`define BATIE_REG_RESET      8'h00

`endif

// ===== verilog/batie_pkg.sv
// types for the bit and transfer instruction executor
// assumes a decoder ahead of it that fills the instruction struct
package batie_pkg;

  // operation selected by the decoder
  typedef enum logic [4:0] {
    OP_NOP, OP_MOV, OP_LDI, OP_SWAP, OP_PAIR_COPY, OP_FLAG_SET, OP_FLAG_CLR,
    OP_BIT_TO_XFER, OP_XFER_TO_BIT, OP_LOAD, OP_STORE, OP_DIRECT_LOAD,
    OP_DIRECT_WRITE, OP_PMEM_READ, OP_PUSH, OP_POP, OP_IO_IN, OP_IO_OUT,
    OP_SLEEP, OP_WDT_RESTART, OP_BREAK
  } batie_op_t;

  // pointer pair choice
  typedef enum logic [1:0] {
    PTR_FIRST, PTR_SECOND, PTR_THIRD
  } batie_ptr_t;

  // pointer addressing mode
  typedef enum logic [1:0] {
    AM_PLAIN, AM_POST_INC, AM_PRE_DEC, AM_DISP
  } batie_amode_t;

  // executor states, one-hot
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_WAIT = 4'b0010,
    S_DATA = 4'b0100,
    S_HOLD = 4'b1000
  } batie_state_t;

  // decoded instruction
  typedef struct packed {
    batie_op_t    op;
    logic [4:0]   rd;
    logic [4:0]   rs;
    logic [2:0]   bsel;
    batie_ptr_t   ptr;
    batie_amode_t amode;
    logic [5:0]   disp;
    logic [15:0]  k;
  } batie_instr_t;

  // data memory request
  typedef struct packed {
    logic        en;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } batie_dmem_req_t;

  // program memory request
  typedef struct packed {
    logic        en;
    logic [15:0] addr;
  } batie_pmem_req_t;

  // i/o space request
  typedef struct packed {
    logic       en;
    logic       we;
    logic [5:0] addr;
    logic [7:0] wdata;
  } batie_io_req_t;

endpackage

// ===== verilog/batie_exec.sv
// executor for bit, flag, transfer and core control instructions
// assumes data memory and i/o answer in the cycle of a registered request, program memory one cycle later
//
// Contract
// - bit_to_transfer_flag copies source bit into transfer flag, one cycle
// - transfer_flag_to_bit writes transfer flag into destination bit, one cycle
// - overflow set and clear force the overflow flag, one cycle
// - half carry set and clear force the half carry flag, one cycle
// - sign set and clear force the sign flag, one cycle
// - post-increment load reads at pointer then bumps pointer; two cycles
// - pre-decrement load drops pointer then reads new address; two cycles
// - displaced_load reads at pointer plus displacement, pointer kept; two cycles
// - post-increment store writes at pointer then bumps pointer; two cycles
// - pre-decrement store drops pointer then writes there; two cycles
// - displaced_write stores at pointer plus displacement, pointer kept; two cycles
// - direct_load reads the immediate address, two cycles, no flags
// - direct_write writes the immediate address, two cycles, no flags
// - program_memory_read fetches byte at third pointer, optional increment; three cycles; code reads at the pair chosen by INSTR_IN.ptr
// - push places source on stack in two cycles, no flags
// - pop loads destination from stack in two cycles, no flags
// - break acts only when on-chip debugging is enabled
// - sleep takes one cycle and signals the sleep unit, no flags
// - watchdog_restart takes one cycle and signals the watchdog, no flags
`timescale 1ns/1ps
`include "batie_defs.svh"

module batie_exec
  import batie_pkg::*;
(
  input  wire logic            CLK_IN,
  input  wire logic            RST_IN,
  input  wire logic            INSTR_VALID_IN,
  input  wire batie_instr_t    INSTR_IN,
  input  wire logic            DEBUG_EN_IN,
  input  wire logic [7:0]      DMEM_RDATA_IN,
  input  wire logic [7:0]      PMEM_RDATA_IN,
  input  wire logic [7:0]      IO_RDATA_IN,
  output logic                 READY_OUT,
  output batie_dmem_req_t      DMEM_REQ_OUT,
  output batie_pmem_req_t      PMEM_REQ_OUT,
  output batie_io_req_t        IO_REQ_OUT,
  output logic [7:0]           STATUS_OUT,
  output logic [15:0]          SP_OUT,
  output logic                 SLEEP_OUT,
  output logic                 WDT_RESTART_OUT,
  output logic                 BREAK_OUT
);

  logic [7:0]       rf [0:31];
  batie_state_t     state;
  batie_state_t     next_state;
  logic [7:0]       status;
  logic [7:0]       next_status;
  logic [15:0]      sp;
  logic [15:0]      next_sp;
  logic [4:0]       load_idx;
  logic [4:0]       next_load_idx;
  logic             load_pmem;
  logic             next_load_pmem;
  logic             pend_io;
  logic             next_pend_io;
  logic [4:0]       pend_idx;
  logic [4:0]       next_pend_idx;
  batie_dmem_req_t  next_dmem;
  batie_pmem_req_t  next_pmem;
  batie_io_req_t    next_io;
  logic             next_sleep;
  logic             next_wdt;
  logic             next_break;
  logic             next_ready;
  logic             wa_en;
  logic [4:0]       wa_idx;
  logic [7:0]       wa_data;
  logic             wb_en;
  logic [4:0]       wb_idx;
  logic [7:0]       wb_data;
  logic             accept;
  logic [4:0]       ptr_lo;
  logic [15:0]      ptr_val;
  logic [15:0]      ptr_addr;
  logic [15:0]      ptr_new;
  logic             ptr_upd;
  logic [7:0]       src;
  logic [7:0]       dst;

  // register read with forwarding of a pending i/o input
  function automatic logic [7:0] rd_reg(input logic [4:0] idx);
    logic [7:0] v;
    v = rf[idx];
    if (pend_io && pend_idx == idx) begin
      v = IO_RDATA_IN;
    end
    return v;
  endfunction

  // pointer selection and address arithmetic
  always_comb begin
    case (INSTR_IN.ptr)
      PTR_FIRST:  ptr_lo = `BATIE_FIRST_PTR_LO;
      PTR_SECOND: ptr_lo = `BATIE_SECOND_PTR_LO;
      default:    ptr_lo = `BATIE_THIRD_PTR_LO;
    endcase
    ptr_val = {rd_reg(ptr_lo + 5'h01), rd_reg(ptr_lo)};
    ptr_addr = ptr_val;
    ptr_new = ptr_val;
    ptr_upd = 1'b0;
    case (INSTR_IN.amode)
      AM_POST_INC: begin
        ptr_new = ptr_val + 16'h0001;
        ptr_upd = 1'b1;
      end
      AM_PRE_DEC: begin
        ptr_addr = ptr_val - 16'h0001;
        ptr_new = ptr_addr;
        ptr_upd = 1'b1;
      end
      AM_DISP: begin
        ptr_addr = ptr_val + {10'h000, INSTR_IN.disp};
      end
      default: begin
        ptr_addr = ptr_val;
      end
    endcase
    src = rd_reg(INSTR_IN.rs);
    dst = rd_reg(INSTR_IN.rd);
  end

  // next state of the executor, flags, stack and requests
  always_comb begin
    accept = (state == S_IDLE) && INSTR_VALID_IN;
    next_state = state;
    next_status = status;
    next_sp = sp;
    next_load_idx = load_idx;
    next_load_pmem = load_pmem;
    next_pend_io = 1'b0;
    next_pend_idx = pend_idx;
    next_dmem = '0;
    next_pmem = '0;
    next_io = '0;
    next_sleep = 1'b0;
    next_wdt = 1'b0;
    next_break = 1'b0;
    wa_en = 1'b0;
    wa_idx = INSTR_IN.rd;
    wa_data = 8'h00;
    wb_en = 1'b0;
    wb_idx = INSTR_IN.rd;
    wb_data = 8'h00;
    case (state)
      S_IDLE: begin
        if (accept) begin
          case (INSTR_IN.op)
            OP_MOV: begin
              wa_en = 1'b1;
              wa_data = src;
            end
            OP_LDI: begin
              wa_en = 1'b1;
              wa_data = INSTR_IN.k[7:0];
            end
            OP_SWAP: begin
              wa_en = 1'b1;
              wa_data = {dst[3:0], dst[7:4]};
            end
            OP_PAIR_COPY: begin
              wa_en = 1'b1;
              wa_idx = {INSTR_IN.rd[4:1], 1'b0};
              wa_data = rd_reg({INSTR_IN.rs[4:1], 1'b0});
              wb_en = 1'b1;
              wb_idx = {INSTR_IN.rd[4:1], 1'b1};
              wb_data = rd_reg({INSTR_IN.rs[4:1], 1'b1});
            end
            OP_FLAG_SET: begin
              next_status[INSTR_IN.bsel] = 1'b1;
            end
            OP_FLAG_CLR: begin
              next_status[INSTR_IN.bsel] = 1'b0;
            end
            OP_BIT_TO_XFER: begin
              next_status[`BATIE_FLAG_XFER] = src[INSTR_IN.bsel];
            end
            OP_XFER_TO_BIT: begin
              wa_en = 1'b1;
              wa_data = dst;
              wa_data[INSTR_IN.bsel] = status[`BATIE_FLAG_XFER];
            end
            OP_LOAD, OP_STORE: begin
              next_dmem.en = 1'b1;
              next_dmem.we = (INSTR_IN.op == OP_STORE);
              next_dmem.addr = ptr_addr;
              next_dmem.wdata = src;
              wa_en = ptr_upd;
              wa_idx = ptr_lo;
              wa_data = ptr_new[7:0];
              wb_en = ptr_upd;
              wb_idx = ptr_lo + 5'h01;
              wb_data = ptr_new[15:8];
              next_load_idx = INSTR_IN.rd;
              next_load_pmem = 1'b0;
              next_state = (INSTR_IN.op == OP_STORE) ? S_HOLD : S_DATA;
            end
            OP_DIRECT_LOAD, OP_DIRECT_WRITE: begin
              next_dmem.en = 1'b1;
              next_dmem.we = (INSTR_IN.op == OP_DIRECT_WRITE);
              next_dmem.addr = INSTR_IN.k;
              next_dmem.wdata = src;
              next_load_idx = INSTR_IN.rd;
              next_load_pmem = 1'b0;
              next_state = (INSTR_IN.op == OP_DIRECT_WRITE) ? S_HOLD : S_DATA;
            end
            OP_PMEM_READ: begin
              next_pmem.en = 1'b1;
              next_pmem.addr = ptr_val;
              wa_en = (INSTR_IN.amode == AM_POST_INC);
              wa_idx = ptr_lo;
              wa_data = ptr_new[7:0];
              wb_en = (INSTR_IN.amode == AM_POST_INC);
              wb_idx = ptr_lo + 5'h01;
              wb_data = ptr_new[15:8];
              next_load_idx = INSTR_IN.rd;
              next_load_pmem = 1'b1;
              next_state = S_WAIT;
            end
            OP_PUSH: begin
              next_dmem.en = 1'b1;
              next_dmem.we = 1'b1;
              next_dmem.addr = sp;
              next_dmem.wdata = src;
              next_sp = sp - 16'h0001;
              next_state = S_HOLD;
            end
            OP_POP: begin
              next_dmem.en = 1'b1;
              next_dmem.addr = sp + 16'h0001;
              next_sp = sp + 16'h0001;
              next_load_idx = INSTR_IN.rd;
              next_load_pmem = 1'b0;
              next_state = S_DATA;
            end
            OP_IO_IN: begin
              next_io.en = 1'b1;
              next_io.addr = INSTR_IN.k[5:0];
              next_pend_io = 1'b1;
              next_pend_idx = INSTR_IN.rd;
            end
            OP_IO_OUT: begin
              next_io.en = 1'b1;
              next_io.we = 1'b1;
              next_io.addr = INSTR_IN.k[5:0];
              next_io.wdata = src;
            end
            OP_SLEEP: begin
              next_sleep = 1'b1;
            end
            OP_WDT_RESTART: begin
              next_wdt = 1'b1;
            end
            OP_BREAK: begin
              next_break = DEBUG_EN_IN;
            end
            default: begin
              next_state = S_IDLE;
            end
          endcase
        end
      end
      S_WAIT: begin
        next_state = S_DATA;
      end
      S_DATA: begin
        wa_en = 1'b1;
        wa_idx = load_idx;
        wa_data = load_pmem ? PMEM_RDATA_IN : DMEM_RDATA_IN;
        next_state = S_IDLE;
      end
      S_HOLD: begin
        next_state = S_IDLE;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
    next_ready = (next_state == S_IDLE);
  end

  // state, flags, stack pointer and registered outputs
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      state <= S_IDLE;
      status <= `BATIE_STATUS_RESET;
      sp <= `BATIE_SP_RESET;
      load_idx <= 5'h00;
      load_pmem <= 1'b0;
      pend_io <= 1'b0;
      pend_idx <= 5'h00;
      READY_OUT <= 1'b1;
      DMEM_REQ_OUT <= '0;
      PMEM_REQ_OUT <= '0;
      IO_REQ_OUT <= '0;
      SLEEP_OUT <= 1'b0;
      WDT_RESTART_OUT <= 1'b0;
      BREAK_OUT <= 1'b0;
    end else begin
      state <= next_state;
      status <= next_status;
      sp <= next_sp;
      load_idx <= next_load_idx;
      load_pmem <= next_load_pmem;
      pend_io <= next_pend_io;
      pend_idx <= next_pend_idx;
      READY_OUT <= next_ready;
      DMEM_REQ_OUT <= next_dmem;
      PMEM_REQ_OUT <= next_pmem;
      IO_REQ_OUT <= next_io;
      SLEEP_OUT <= next_sleep;
      WDT_RESTART_OUT <= next_wdt;
      BREAK_OUT <= next_break;
    end
  end

  // working registers; later writes in a cycle win over the i/o return
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      for (int i = 0; i < 32; i++) begin
        rf[i] <= `BATIE_REG_RESET;
      end
    end else begin
      if (pend_io) begin
        rf[pend_idx] <= IO_RDATA_IN;
      end
      if (wa_en) begin
        rf[wa_idx] <= wa_data;
      end
      if (wb_en) begin
        rf[wb_idx] <= wb_data;
      end
    end
  end

  // status register is visible as is
  assign STATUS_OUT = status;
  assign SP_OUT = sp;

endmodule

// ===== tb/batie_exec_assertions.sv
// concurrent checks on the executor's ports
// assumes binding onto batie_exec, one clock, synchronous reset
`timescale 1ns/1ps
module batie_exec_assertions
  import batie_pkg::*;
(
  input wire logic            CLK_IN,
  input wire logic            RST_IN,
  input wire logic            INSTR_VALID_IN,
  input wire batie_instr_t    INSTR_IN,
  input wire logic            DEBUG_EN_IN,
  input wire logic [7:0]      DMEM_RDATA_IN,
  input wire logic [7:0]      PMEM_RDATA_IN,
  input wire logic [7:0]      IO_RDATA_IN,
  input wire logic            READY_OUT,
  input wire batie_dmem_req_t DMEM_REQ_OUT,
  input wire batie_pmem_req_t PMEM_REQ_OUT,
  input wire batie_io_req_t   IO_REQ_OUT,
  input wire logic [7:0]      STATUS_OUT,
  input wire logic [15:0]     SP_OUT,
  input wire logic            SLEEP_OUT,
  input wire logic            WDT_RESTART_OUT,
  input wire logic            BREAK_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  logic take;
  // instruction accepted this edge
  assign take = READY_OUT && INSTR_VALID_IN;
  // busy shapes and memory request kinds
  sequence s_busy2; !READY_OUT ##1 READY_OUT; endsequence
  sequence s_busy3; !READY_OUT [*2] ##1 READY_OUT; endsequence
  sequence s_rd; DMEM_REQ_OUT.en && !DMEM_REQ_OUT.we; endsequence
  sequence s_wr; DMEM_REQ_OUT.en && DMEM_REQ_OUT.we; endsequence
  property p_load; take && INSTR_IN.op == OP_LOAD |=> s_rd ##0 s_busy2; endproperty
  a_load: assert property (p_load) else $error("load shape wrong");
  property p_store; take && INSTR_IN.op == OP_STORE |=> s_wr ##0 s_busy2; endproperty
  a_store: assert property (p_store) else $error("store shape wrong");
  property p_dload;
    take && INSTR_IN.op == OP_DIRECT_LOAD |=> s_rd ##0 DMEM_REQ_OUT.addr == $past(INSTR_IN.k) ##0 s_busy2;
  endproperty
  a_dload: assert property (p_dload) else $error("direct load wrong");
  property p_pmem; take && INSTR_IN.op == OP_PMEM_READ |=> PMEM_REQ_OUT.en ##0 s_busy3; endproperty
  a_pmem: assert property (p_pmem) else $error("program read shape wrong");
  property p_push;
    take && INSTR_IN.op == OP_PUSH |=> s_wr ##0 DMEM_REQ_OUT.addr == $past(SP_OUT) ##0 s_busy2;
  endproperty
  a_push: assert property (p_push) else $error("push wrong");
  property p_pop;
    take && INSTR_IN.op == OP_POP |=> s_rd ##0 DMEM_REQ_OUT.addr == $past(SP_OUT) + 16'h1 ##0 s_busy2;
  endproperty
  a_pop: assert property (p_pop) else $error("pop wrong");
  property p_fset;
    take && INSTR_IN.op == OP_FLAG_SET |=> STATUS_OUT == ($past(STATUS_OUT) | (8'h01 << $past(INSTR_IN.bsel)));
  endproperty
  a_fset: assert property (p_fset) else $error("flag set wrong");
  property p_fclr;
    take && INSTR_IN.op == OP_FLAG_CLR |=> STATUS_OUT == ($past(STATUS_OUT) & ~(8'h01 << $past(INSTR_IN.bsel)));
  endproperty
  a_fclr: assert property (p_fclr) else $error("flag clear wrong");
  property p_bxfer;
    take && INSTR_IN.op == OP_BIT_TO_XFER |=> (STATUS_OUT & 8'hbf) == $past(STATUS_OUT & 8'hbf);
  endproperty
  a_bxfer: assert property (p_bxfer) else $error("other flags moved");
  property p_quiet;
    take && INSTR_IN.op inside {OP_XFER_TO_BIT, OP_SLEEP, OP_WDT_RESTART, OP_IO_IN, OP_IO_OUT, OP_PUSH, OP_POP}
      |=> $stable(STATUS_OUT);
  endproperty
  a_quiet: assert property (p_quiet) else $error("flags moved");
  property p_sleep; take && INSTR_IN.op == OP_SLEEP |=> SLEEP_OUT && READY_OUT; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep pulse missing");
  property p_wdog; take && INSTR_IN.op == OP_WDT_RESTART |=> WDT_RESTART_OUT && READY_OUT; endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog pulse missing");
  property p_brk; take && INSTR_IN.op == OP_BREAK |=> BREAK_OUT == $past(DEBUG_EN_IN); endproperty
  a_brk: assert property (p_brk) else $error("break pulse wrong");
  property p_out; take && INSTR_IN.op == OP_IO_OUT |=> IO_REQ_OUT.en && IO_REQ_OUT.we && READY_OUT; endproperty
  a_out: assert property (p_out) else $error("io write wrong");
endmodule
bind batie_exec batie_exec_assertions chk_u (.CLK_IN, .RST_IN, .INSTR_VALID_IN, .INSTR_IN, .DEBUG_EN_IN,
  .DMEM_RDATA_IN, .PMEM_RDATA_IN, .IO_RDATA_IN, .READY_OUT, .DMEM_REQ_OUT, .PMEM_REQ_OUT, .IO_REQ_OUT,
  .STATUS_OUT, .SP_OUT, .SLEEP_OUT, .WDT_RESTART_OUT, .BREAK_OUT);

// ===== tb/tb_top.sv
// self-checking bench for the bit and transfer executor
// assumes the bench answers memory and i/o reads in place of the far side
`timescale 1ns/1ps
module tb_top;
  import batie_pkg::*;
  logic            clk_in, rst_in, instr_valid_in, debug_en_in;
  batie_instr_t    instr_in;
  logic [7:0]      dmem_rdata_in, pmem_rdata_in, io_rdata_in, status_out;
  logic            ready_out, sleep_out, wdt_restart_out, break_out;
  batie_dmem_req_t dmem_req_out;
  batie_pmem_req_t pmem_req_out;
  batie_io_req_t   io_req_out;
  logic [15:0]     sp_out;
  batie_ptr_t      ptr_sel;
  int              n_errors, comparisons;

  batie_exec dut_u (.CLK_IN(clk_in), .RST_IN(rst_in), .INSTR_VALID_IN(instr_valid_in), .INSTR_IN(instr_in),
    .DEBUG_EN_IN(debug_en_in), .DMEM_RDATA_IN(dmem_rdata_in), .PMEM_RDATA_IN(pmem_rdata_in),
    .IO_RDATA_IN(io_rdata_in), .READY_OUT(ready_out), .DMEM_REQ_OUT(dmem_req_out), .PMEM_REQ_OUT(pmem_req_out),
    .IO_REQ_OUT(io_req_out), .STATUS_OUT(status_out), .SP_OUT(sp_out), .SLEEP_OUT(sleep_out),
    .WDT_RESTART_OUT(wdt_restart_out), .BREAK_OUT(break_out));

  task automatic wrap_up();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // present one instruction, hold until taken, return mid next cycle
  task automatic ex(input batie_op_t o, input int d, input int r, input int b, input batie_amode_t m, input int k);
    instr_in = '{o, 5'(d), 5'(r), 3'(b), ptr_sel, m, 6'(k), 16'(k)};
    instr_valid_in = 1'b1;
    do @(posedge clk_in); while (ready_out !== 1'b1);
    @(negedge clk_in);
  endtask

  task automatic gap(input int n);
    instr_valid_in = 1'b0;
    repeat (n) @(negedge clk_in);
  endtask

  // register fill and readback through direct transfers
  task automatic ldr(input int d, input logic [7:0] v);
    ex(OP_DIRECT_LOAD, d, 0, 0, AM_PLAIN, 16'h0123);
    dmem_rdata_in = v;
    chk({dmem_req_out.en, dmem_req_out.we, dmem_req_out.addr, ready_out}, {2'b10, 16'h0123, 1'b0});
  endtask

  task automatic stw(input int r, input logic [7:0] v);
    ex(OP_DIRECT_WRITE, 0, r, 0, AM_PLAIN, 16'h0200);
    chk({dmem_req_out.en, dmem_req_out.we, dmem_req_out.addr, dmem_req_out.wdata}, {2'b11, 16'h0200, v});
  endtask

  task automatic t_flags();
    logic [7:0] e;
    e = 8'h00;
    for (int c = 0; c < 2; c++) begin
      for (int s = 0; s < 8; s++) begin
        ex(c ? OP_FLAG_CLR : OP_FLAG_SET, 0, 0, s, AM_PLAIN, 0);
        e[s] = !c;
        chk(status_out, e);
      end
    end
  endtask

  task automatic t_bits();
    ldr(16, 8'h5a);
    ex(OP_BIT_TO_XFER, 0, 16, 1, AM_PLAIN, 0);
    chk(status_out, 8'h40);
    ex(OP_BIT_TO_XFER, 0, 16, 0, AM_PLAIN, 0);
    chk(status_out, 8'h00);
    ex(OP_BIT_TO_XFER, 0, 16, 6, AM_PLAIN, 0);
    ex(OP_XFER_TO_BIT, 17, 0, 7, AM_PLAIN, 0);
    chk(status_out, 8'h40);
    stw(17, 8'h80);
    stw(16, 8'h5a);
  endtask

  task automatic t_ptr();
    batie_amode_t am[3];
    int dp[6];
    logic [15:0] ea[6];
    am = '{AM_POST_INC, AM_PRE_DEC, AM_DISP};
    dp = '{0, 0, 'h3f, 0, 0, 1};
    ea = '{16'h01ff, 16'h01ff, 16'h023e, 16'h01ff, 16'h01ff, 16'h0200};
    ptr_sel = PTR_SECOND;
    ldr(28, 8'hff);
    ldr(29, 8'h01);
    for (int i = 0; i < 6; i++) begin
      ex(i < 3 ? OP_LOAD : OP_STORE, 2, 16, 0, am[i % 3], dp[i]);
      dmem_rdata_in = 8'h96;
      chk({dmem_req_out.en, dmem_req_out.we}, {1'b1, i >= 3});
      chk(dmem_req_out.addr, ea[i]);
      if (i >= 3) chk(dmem_req_out.wdata, 8'h5a);
    end
    stw(28, 8'hff);
    stw(29, 8'h01);
    stw(2, 8'h96);
  endtask

  task automatic t_pmem();
    ptr_sel = PTR_THIRD;
    ldr(30, 8'h10);
    ldr(31, 8'h00);
    ex(OP_PMEM_READ, 3, 0, 0, AM_POST_INC, 0);
    pmem_rdata_in = 8'ha5;
    chk({pmem_req_out.en, pmem_req_out.addr, ready_out}, {1'b1, 16'h0010, 1'b0});
    gap(1);
    chk(ready_out, 1'b0);
    ex(OP_PMEM_READ, 0, 0, 0, AM_PLAIN, 0);
    pmem_rdata_in = 8'h3c;
    chk({pmem_req_out.en, pmem_req_out.addr}, {1'b1, 16'h0011});
    stw(3, 8'ha5);
    stw(0, 8'h3c);
  endtask

  task automatic t_stack();
    ex(OP_PUSH, 0, 16, 0, AM_PLAIN, 0);
    chk({dmem_req_out.we, dmem_req_out.addr, dmem_req_out.wdata}, {1'b1, 16'h00ff, 8'h5a});
    gap(2);
    chk(sp_out, 16'h00fe);
    ex(OP_POP, 4, 0, 0, AM_PLAIN, 0);
    dmem_rdata_in = 8'h77;
    chk({dmem_req_out.en, dmem_req_out.we, dmem_req_out.addr}, {2'b10, 16'h00ff});
    gap(2);
    chk({sp_out, status_out}, {16'h00ff, 8'h40});
    stw(4, 8'h77);
  endtask

  task automatic t_ctrl();
    ex(OP_SLEEP, 0, 0, 0, AM_PLAIN, 0);
    chk({sleep_out, wdt_restart_out, break_out, ready_out}, 4'b1001);
    ex(OP_WDT_RESTART, 0, 0, 0, AM_PLAIN, 0);
    chk({sleep_out, wdt_restart_out, break_out, ready_out}, 4'b0101);
    ex(OP_BREAK, 0, 0, 0, AM_PLAIN, 0);
    chk({sleep_out, wdt_restart_out, break_out}, 3'b000);
    debug_en_in = 1'b1;
    ex(OP_BREAK, 0, 0, 0, AM_PLAIN, 0);
    chk({sleep_out, wdt_restart_out, break_out}, 3'b001);
    ex(OP_IO_OUT, 0, 16, 0, AM_PLAIN, 'h3f);
    chk({io_req_out.en, io_req_out.we, io_req_out.addr, io_req_out.wdata}, {2'b11, 6'h3f, 8'h5a});
    ex(OP_IO_IN, 5, 0, 0, AM_PLAIN, 'h21);
    io_rdata_in = 8'hc3;
    chk({io_req_out.en, io_req_out.we, io_req_out.addr, ready_out}, {2'b10, 6'h21, 1'b1});
    ex(OP_PAIR_COPY, 6, 16, 0, AM_PLAIN, 0);
    chk(ready_out, 1'b1);
    stw(6, 8'h5a);
    stw(7, 8'h80);
    stw(5, 8'hc3);
    chk(status_out, 8'h40);
  endtask

  // register moves and nibble swap, read back by direct writes
  task automatic t_move();
    ex(OP_LDI, 8, 0, 0, AM_PLAIN, 'h3c);
    ex(OP_MOV, 9, 8, 0, AM_PLAIN, 0);
    ex(OP_SWAP, 9, 0, 0, AM_PLAIN, 0);
    stw(8, 8'h3c);
    stw(9, 8'hc3);
  endtask

  // free-running clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // hang guard
  initial begin
    #20us;
    n_errors++;
    wrap_up();
  end

  // reset then scenarios
  initial begin
    rst_in = 1'b1;
    instr_valid_in = 1'b0;
    instr_in = '0;
    debug_en_in = 1'b0;
    dmem_rdata_in = 8'h00;
    pmem_rdata_in = 8'h00;
    io_rdata_in = 8'h00;
    ptr_sel = PTR_SECOND;
    n_errors = 0;
    comparisons = 0;
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'b0;
    chk({ready_out, status_out, sp_out}, {1'b1, 8'h00, 16'h00ff});
    t_flags();
    t_bits();
    t_ptr();
    t_pmem();
    t_stack();
    t_ctrl();
    t_move();
    gap(2);
    wrap_up();
  end
endmodule
